// file: design/dai_pkg.sv
// Shared constants, types and helpers for the audio serial port host.
package dai_pkg;

  // Register map of the codec (reached over its own control bus).
  localparam logic [7:0] REG_OUT_STANDBY = 8'h04;
  localparam logic [7:0] REG_IN_STANDBY  = 8'h05;
  localparam logic [7:0] REG_LOOP_SRC    = 8'h25;
  localparam logic [7:0] REG_FORMAT_CFG  = 8'h26;
  localparam logic [7:0] REG_SLOT_OFFSET = 8'h27;
  localparam logic [7:0] REG_PORT_ENABLE = 8'h28;
  localparam logic [7:0] REG_CLK_SYNTH   = 8'h2c;

  // Link timing.
  localparam int CLK_PERIOD_NS  = 40;
  localparam int BCLK_PERIOD_NS = 320;
  localparam int BCLK_HALF_CYC  = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DATA_W         = 32;
  localparam int FIFO_DEPTH     = 8;

  // Word and frame lengths in bits.
  localparam logic [5:0] WL_16  = 6'h10;
  localparam logic [5:0] WL_20  = 6'h14;
  localparam logic [5:0] WL_24  = 6'h18;
  localparam logic [5:0] WL_32  = 6'h20;
  localparam logic [8:0] FR_256 = 9'h100;
  localparam logic [8:0] FR_128 = 9'h080;
  localparam logic [8:0] FR_64  = 9'h040;

  typedef enum logic [1:0] {
    FMT_I2S = 2'h0,
    FMT_LJ  = 2'h1,
    FMT_RJ  = 2'h2,
    FMT_DSP = 2'h3
  } dai_fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SYNC = 3'h2,
    ST_RUN  = 3'h4
  } dai_state_t;

  typedef struct packed {
    logic        port_en;
    logic        codec_master;
    dai_fmt_t    fmt;
    logic [1:0]  word_sel;
    logic [1:0]  frame_sel;
    logic        slot_en;
    logic        slot_mono;
    logic [7:0]  slot_offset;
  } dai_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] left;
    logic [DATA_W-1:0] right;
  } dai_pair_t;

  typedef struct packed {
    logic       hit;
    logic       right;
    logic [5:0] k;
  } dai_slot_t;

  function automatic logic [5:0] wl_bits(input logic [1:0] sel);
    logic [5:0] r;
    unique case (sel)
      2'h0: r = WL_16;
      2'h1: r = WL_20;
      2'h2: r = WL_24;
      2'h3: r = WL_32;
    endcase
    return r;
  endfunction : wl_bits

  function automatic logic [8:0] frame_bits(input logic [1:0] fsel, input logic [1:0] wsel);
    logic [8:0] r;
    unique case (fsel)
      2'h0: r = {2'h0, wl_bits(wsel), 1'b0};
      2'h1: r = FR_256;
      2'h2: r = FR_128;
      2'h3: r = FR_64;
    endcase
    return r;
  endfunction : frame_bits

endpackage : dai_pkg

// file: design/dai_fifo.sv
// Sample FIFO with registered read data and registered ready.
`timescale 1ns/1ps
module dai_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  // Pointers wrap naturally, so DEPTH must be a power of two.
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          load;

  assign push = in_valid & in_ready;
  assign load = (cnt_r != '0) & (~out_valid | out_ready);

  always_comb begin
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(load);
      cnt_r    <= cnt_nxt;
      in_ready <= cnt_nxt != FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : dai_fifo

// file: design/dai_host.sv
// Host end of the codec serial audio port: clocks, framing and sample transfer.
//
// Notes on behaviour
// R1: The codec's port runs only while its port enable bit is set.
// R2: Drive data and framing on falling bit clock, sample on rising.
// R3: Codec master drives both clocks; codec slave needs the host to drive them.
// R4: Clearing codec transmit enable stops it driving its serial output.
// R5: Samples are two's complement, most significant bit first, every format.
// R6: Word length is 16, 20, 24 or 32 bits both ways.
// R7: Master frame is twice word length, 256, 128 or 64 bit clocks.
// R8: A slave-side frame may have any bit count that fits all data bits.
// R9: Right-justified: word clock high is left; LSB ends just before the toggle.
// R10: Left-justified: word clock high is left; MSB on first rise after edge.
// R11: I2S: word clock low is left; MSB on second rise after transition.
// R12: DSP: rising word clock starts frame; left then right with no gap.
// R13: Slot mode places data an offset of bit periods after frame start.
// R14: Left-justified slots: each channel starts offset bits after its word edge.
// R15: DSP slots: left starts offset after pulse, right follows directly.
// R16: Codec output floats whenever its own data is not valid.
// R17: Single-channel slot mode moves only the left word.
// R18: Right transmit source control merges mono loopback data into output.
// R19: Loop source select replaces transmit left with received right data.
// R20: System clock is 12.288 or 11.2896 MHz per sample-rate family.
// R21: A master clock of 10 to 80 MHz must run before any setup.
// R22: Until the synthesiser locks, register writes use the control bus clock.
// R23: Block enables precede master enable; standby bits move blocks afterwards.
// R24: Master on 12.288 or 11.2896 MHz bypasses the synthesiser.
// R25: Converter ratios per sample rate follow a fixed table.
// R26: Slot mode is unavailable at 96 kHz.
// R27: Slave role is role select zero, with both clocks supplied externally.
// R28: A disabled port floats its data output and ignores incoming data; the host drives serial_in_o low instead of floating it.
`timescale 1ns/1ps
module dai_host (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Port configuration, mirrors what was written to the codec
  input  wire dai_pkg::dai_cfg_t cfg,
  // Samples to send
  input  wire logic              tx_valid,
  input  wire dai_pkg::dai_pair_t tx_data,
  output logic                   tx_ready,
  // Samples received
  output logic                   rx_valid,
  output dai_pkg::dai_pair_t     rx_data,
  // Codec master clock
  output logic                   mclk_o,
  // Bit clock pin
  output logic                   bclk_o,
  output logic                   bclk_oe,
  input  wire logic              bclk_i,
  // Word clock pin
  output logic                   wclk_o,
  output logic                   wclk_oe,
  input  wire logic              wclk_i,
  // Serial data to and from the codec
  output logic                   serial_in_o,
  input  wire logic              serial_out_i,
  // Status
  output logic                   synced
);

  localparam logic [3:0] HALF_LAST = 4'(dai_pkg::BCLK_HALF_CYC - 1);

  dai_pkg::dai_state_t st_r;
  dai_pkg::dai_pair_t  cur_tx_r;
  dai_pkg::dai_pair_t  fifo_data;
  dai_pkg::dai_pair_t  word_src;
  dai_pkg::dai_slot_t  tx_slot;
  dai_pkg::dai_slot_t  rx_slot;

  logic [2:0]  bclk_sy_r;
  logic [2:0]  wclk_sy_r;
  logic [1:0]  sdo_sy_r;
  logic [3:0]  div_cnt_r;
  logic        bclk_r;
  logic [8:0]  pos_r;
  logic        chan_r;
  logic [8:0]  pos_nxt;
  logic        chan_nxt;
  logic [8:0]  seg_len;
  logic [8:0]  seg_cnt_r;
  logic [8:0]  meas_len_r;
  logic        wprev_r;
  logic        started_r;
  logic [31:0] rx_sh_l_r;
  logic [31:0] rx_sh_r_r;
  logic [31:0] rx_l_nxt;
  logic [31:0] rx_r_nxt;
  logic [5:0]  wl;
  logic        host_master;
  logic        cm;
  logic        is_dsp;
  logic        host_tick;
  logic        ev_rise;
  logic        ev_fall;
  logic        seg_last;
  logic        frame_start;
  logic        start_edge;
  logic        edge_chan;
  logic [8:0]  eff_pos;
  logic        eff_chan;
  logic        fifo_valid;
  logic        pop;
  logic        rx_done;

  // Places a position of the segment onto a data bit of one channel.
  function automatic dai_pkg::dai_slot_t slot_of(
    input dai_pkg::dai_cfg_t c,
    input logic [8:0]        seg,
    input logic              ch,
    input logic [8:0]        p
  );
    dai_pkg::dai_slot_t s;
    logic [9:0] w;
    logic [9:0] off;
    logic [9:0] st;
    logic [9:0] rel;
    s   = '0;
    w   = {4'h0, dai_pkg::wl_bits(c.word_sel)};
    off = c.slot_en ? {2'h0, c.slot_offset} : 10'h000;
    st  = off;
    s.right = ch;
    unique case (c.fmt)
      dai_pkg::FMT_I2S: begin
        st = off + 10'h001; // R11
      end
      dai_pkg::FMT_LJ: begin
        st = off; // R10 R14
      end
      dai_pkg::FMT_RJ: begin
        st = {1'b0, seg} - w; // R9
      end
      dai_pkg::FMT_DSP: begin
        s.right = 1'b0; // R12
        if ({1'b0, p} >= off + w) begin
          st      = off + w; // R15
          s.right = 1'b1;
        end
      end
    endcase
    rel   = {1'b0, p} - st;
    s.hit = ({1'b0, p} >= st) && (rel < w) && !(c.slot_en && c.slot_mono && s.right); // R13 R17
    s.k   = rel[5:0];
    return s;
  endfunction : slot_of

  // Most significant bit of the active word length goes out first.
  function automatic logic word_bit(input logic [31:0] v, input logic [5:0] w, input logic [5:0] k);
    logic [5:0] idx;
    idx = w - 6'h01 - k; // R5
    return v[idx[4:0]];
  endfunction : word_bit

  // Sign extension keeps received words in two's complement at full width.
  function automatic logic [31:0] sext(input logic [31:0] v, input logic [5:0] w);
    logic [5:0] sh;
    sh = dai_pkg::WL_32 - w;
    return 32'($signed(v << sh) >>> sh); // R5
  endfunction : sext

  assign wl          = dai_pkg::wl_bits(cfg.word_sel); // R6
  assign host_master = cfg.port_en & ~cfg.codec_master; // R3 R27
  assign cm          = cfg.codec_master;
  assign is_dsp      = cfg.fmt == dai_pkg::FMT_DSP;

  // Pins from the codec pass two flops before use.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bclk_sy_r <= '0;
      wclk_sy_r <= '0;
      sdo_sy_r  <= '0;
    end else begin
      bclk_sy_r <= {bclk_sy_r[1:0], bclk_i};
      wclk_sy_r <= {wclk_sy_r[1:0], wclk_i};
      sdo_sy_r  <= {sdo_sy_r[0], serial_out_i};
    end
  end

  // Free-running half-rate toggle keeps the codec master clock inside its range.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mclk_o <= 1'b0;
    end else begin
      mclk_o <= ~mclk_o; // R21
    end
  end

  // Bit clock divider used when the codec is slave.
  assign host_tick = div_cnt_r == HALF_LAST;

  always_ff @(posedge ref_clk) begin
    if (reset || !host_master || st_r == dai_pkg::ST_IDLE) begin
      div_cnt_r <= '0;
      bclk_r    <= 1'b0;
    end else if (host_tick) begin
      div_cnt_r <= '0;
      bclk_r    <= ~bclk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  always_comb begin
    ev_rise = 1'b0;
    ev_fall = 1'b0;
    if (st_r != dai_pkg::ST_IDLE) begin
      if (cm) begin
        ev_rise = bclk_sy_r[1] & ~bclk_sy_r[2]; // R2
        ev_fall = ~bclk_sy_r[1] & bclk_sy_r[2];
      end else begin
        ev_rise = host_tick & ~bclk_r;
        ev_fall = host_tick & bclk_r;
      end
    end
  end

  // Segment is one channel half, or the whole frame in DSP format.
  always_comb begin
    if (cm) begin
      seg_len = meas_len_r; // R8
    end else if (is_dsp) begin
      seg_len = dai_pkg::frame_bits(cfg.frame_sel, cfg.word_sel); // R7
    end else begin
      seg_len = dai_pkg::frame_bits(cfg.frame_sel, cfg.word_sel) >> 1;
    end
  end

  always_comb begin
    seg_last    = ({1'b0, pos_r} + 10'h001) >= {1'b0, seg_len};
    pos_nxt     = seg_last ? 9'h000 : pos_r + 9'h001;
    chan_nxt    = (seg_last && !is_dsp) ? ~chan_r : chan_r;
    frame_start = seg_last && (is_dsp || chan_r);
  end

  // Frame edges seen on the codec's word clock.
  always_comb begin
    if (is_dsp) begin
      start_edge = cm & wclk_sy_r[1] & ~wprev_r; // R12
    end else begin
      start_edge = cm & (wclk_sy_r[1] != wprev_r);
    end
    edge_chan = (cfg.fmt == dai_pkg::FMT_I2S) ? wclk_sy_r[1] : ~wclk_sy_r[1]; // R9 R10 R11
    if (is_dsp) begin
      edge_chan = 1'b0;
    end
    eff_pos  = start_edge ? 9'h000 : pos_r;
    eff_chan = start_edge ? edge_chan : chan_r;
  end

  // Segment length is learned from the codec when it owns the clocks.
  always_ff @(posedge ref_clk) begin
    if (reset || st_r == dai_pkg::ST_IDLE) begin
      wprev_r    <= 1'b0;
      seg_cnt_r  <= '0;
      meas_len_r <= '1;
      started_r  <= 1'b0;
    end else if (ev_rise && cm) begin
      wprev_r <= wclk_sy_r[1];
      if (start_edge) begin
        seg_cnt_r <= 9'h001;
        started_r <= 1'b1;
        if (started_r) begin
          meas_len_r <= seg_cnt_r;
        end
      end else begin
        seg_cnt_r <= seg_cnt_r + 9'h001;
      end
    end
  end

  // Link state: idle while disabled, locked to frames while running.
  // The status output is set alongside the state so that it leaves a flop directly.
  always_ff @(posedge ref_clk) begin
    if (reset || !cfg.port_en) begin
      st_r   <= dai_pkg::ST_IDLE; // R1 R28
      synced <= 1'b0;
    end else begin
      unique case (st_r)
        dai_pkg::ST_IDLE: begin
          st_r   <= cm ? dai_pkg::ST_SYNC : dai_pkg::ST_RUN;
          synced <= !cm;
        end
        dai_pkg::ST_SYNC: begin
          if (ev_rise && start_edge && started_r) begin
            st_r   <= dai_pkg::ST_RUN;
            synced <= 1'b1;
          end
        end
        dai_pkg::ST_RUN: begin
          st_r <= dai_pkg::ST_RUN;
        end
        default: begin
          st_r   <= dai_pkg::ST_IDLE;
          synced <= 1'b0;
        end
      endcase
    end
  end
  // Bit position tracking; the codec's word edge corrects any drift.
  always_ff @(posedge ref_clk) begin
    if (reset || st_r == dai_pkg::ST_IDLE) begin
      pos_r  <= '1;
      chan_r <= 1'b1;
    end else if (ev_fall) begin
      pos_r  <= pos_nxt; // R2
      chan_r <= chan_nxt;
    end else if (ev_rise && start_edge) begin
      pos_r  <= 9'h000;
      chan_r <= edge_chan;
    end
  end

  // A frame with no queued sample goes out as silence.
  assign pop = ev_fall && frame_start && st_r == dai_pkg::ST_RUN;

  dai_fifo #(
    .W     ($bits(dai_pkg::dai_pair_t)),
    .DEPTH (dai_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst       (reset),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );

  always_comb begin
    word_src = cur_tx_r;
    if (frame_start) begin
      word_src = fifo_valid ? fifo_data : '0;
    end
    tx_slot = slot_of(cfg, seg_len, chan_nxt, pos_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_tx_r <= '0;
    end else if (pop) begin
      cur_tx_r <= word_src;
    end
  end

  // Transmit bit and host-made framing change on the falling edge.
  always_ff @(posedge ref_clk) begin
    if (reset || !cfg.port_en || st_r == dai_pkg::ST_IDLE) begin
      serial_in_o <= 1'b0; // R28
    end else if (ev_fall) begin
      serial_in_o <= 1'b0;
      if (st_r == dai_pkg::ST_RUN && tx_slot.hit) begin
        serial_in_o <= word_bit(tx_slot.right ? word_src.right : word_src.left, wl, tx_slot.k); // R2
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bclk_o  <= 1'b0;
      bclk_oe <= 1'b0;
      wclk_o  <= 1'b0;
      wclk_oe <= 1'b0;
    end else begin
      // The pin takes the divider's next value, so it falls in the same cycle as data and framing change.
      bclk_o  <= (host_master && st_r != dai_pkg::ST_IDLE) ? (bclk_r ^ host_tick) : 1'b0; // R2
      bclk_oe <= host_master; // R3
      wclk_oe <= host_master;
      if (!host_master) begin
        wclk_o <= 1'b0;
      end else if (ev_fall) begin
        if (is_dsp) begin
          wclk_o <= pos_nxt == 9'h000; // R12
        end else begin
          wclk_o <= ~chan_nxt ^ (cfg.fmt == dai_pkg::FMT_I2S); // R9 R10 R11
        end
      end
    end
  end

  // Receive on the rising edge; bits outside the codec's slot are floating and skipped.
  always_comb begin
    rx_slot  = slot_of(cfg, seg_len, eff_chan, eff_pos);
    rx_l_nxt = {rx_sh_l_r[30:0], sdo_sy_r[1]};
    rx_r_nxt = {rx_sh_r_r[30:0], sdo_sy_r[1]};
    rx_done  = rx_slot.hit && rx_slot.k == wl - 6'h01
               && (rx_slot.right || (cfg.slot_en && cfg.slot_mono)); // R16 R17
  end

  always_ff @(posedge ref_clk) begin
    if (reset || st_r == dai_pkg::ST_IDLE) begin
      rx_sh_l_r <= '0;
      rx_sh_r_r <= '0;
    end else if (ev_rise && st_r == dai_pkg::ST_RUN && rx_slot.hit) begin
      if (rx_slot.right) begin
        rx_sh_r_r <= rx_r_nxt; // R2
      end else begin
        rx_sh_l_r <= rx_l_nxt;
        rx_sh_r_r <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (ev_rise && st_r == dai_pkg::ST_RUN && rx_done) begin
        rx_valid      <= 1'b1;
        rx_data.left  <= sext(rx_slot.right ? rx_sh_l_r : rx_l_nxt, wl); // R5
        rx_data.right <= rx_slot.right ? sext(rx_r_nxt, wl) : '0;
      end
    end
  end

endmodule : dai_host

// file: verif/dai_host_checker.sv
// Concurrent checks on the pins of the audio serial port host.
`timescale 1ns/1ps
module dai_host_checker (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // Configuration
  input wire dai_pkg::dai_cfg_t cfg,
  // Watched outputs
  input wire logic              rx_valid,
  input wire logic              mclk_o,
  input wire logic              bclk_o,
  input wire logic              bclk_oe,
  input wire logic              wclk_o,
  input wire logic              wclk_oe,
  input wire logic              serial_in_o
);
  int unsigned cyc_r;
  int unsigned wl_n;
  int unsigned frame_n;
  logic        wq_r;
  logic        seen_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  assign wl_n    = (cfg.word_sel == 2'h3) ? 32 : 16 + 4 * cfg.word_sel;
  assign frame_n = (cfg.frame_sel == 2'h0) ? 2 * wl_n : (cfg.frame_sel == 2'h1) ? 256 :
                   (cfg.frame_sel == 2'h2) ? 128 : 64;

  // The first frame after enable has no earlier start to measure from, so it is skipped.
  always_ff @(posedge ref_clk) begin
    wq_r <= wclk_o;
    if (reset || !cfg.port_en) begin
      cyc_r  <= 0;
      seen_r <= 1'b0;
    end else if (wclk_o && !wq_r) begin
      cyc_r  <= 1;
      seen_r <= 1'b1;
    end else begin
      cyc_r <= cyc_r + 1;
    end
  end

  sequence s_high_phase;
    bclk_o [*4] ##1 !bclk_o;
  endsequence

  sequence s_low_phase;
    !bclk_o [*4] ##1 bclk_o;
  endsequence

  a_bclk_high_time: assert property (disable iff (reset || !cfg.port_en)
    $rose(bclk_o) && bclk_oe |-> s_high_phase) else $error("bit clock high phase wrong");
  a_bclk_low_time: assert property (disable iff (reset || !cfg.port_en)
    $fell(bclk_o) && bclk_oe |-> s_low_phase) else $error("bit clock low phase wrong");
  a_frame_period: assert property (disable iff (reset || !cfg.port_en)
    wclk_o && !wq_r && seen_r && bclk_oe |-> cyc_r == 2 * dai_pkg::BCLK_HALF_CYC * frame_n)
    else $error("frame length wrong");
  a_data_change_low: assert property (disable iff (reset || !cfg.port_en)
    $changed(serial_in_o) && bclk_oe |-> !bclk_o) else $error("data changed while bit clock high");
  a_wclk_change_low: assert property (disable iff (reset || !cfg.port_en)
    $changed(wclk_o) && wclk_oe |-> !bclk_o) else $error("word clock changed while bit clock high");
  a_role_drive: assert property (
    (cfg.port_en && !cfg.codec_master) [*3] |-> bclk_oe && wclk_oe) else $error("host not driving clocks");
  a_role_listen: assert property (
    cfg.codec_master [*2] |-> !bclk_oe && !wclk_oe) else $error("host drives clocks of codec master");
  a_idle_quiet: assert property (
    !cfg.port_en [*2] |-> !bclk_oe && !wclk_oe && !serial_in_o) else $error("disabled port not quiet");
  a_rx_single: assert property (
    rx_valid && bclk_oe |-> bclk_o ##1 !rx_valid [*8]) else $error("receive pulse misplaced");
  a_mclk_runs: assert property (
    !$past(reset) |-> $changed(mclk_o)) else $error("master clock stopped");
endmodule : dai_host_checker

bind dai_host dai_host_checker u_checker (.ref_clk(ref_clk), .reset(reset), .cfg(cfg), .rx_valid(rx_valid),
  .mclk_o(mclk_o), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_o(wclk_o), .wclk_oe(wclk_oe),
  .serial_in_o(serial_in_o));

// file: verif/dai_codec_model.sv
// Behavioural codec end of the serial audio port that echoes each bit one frame later.
`timescale 1ns/1ps
module dai_codec_model (
  // Controls
  input  wire logic       en,
  input  wire logic       out_en,
  input  wire logic       master,
  input  wire logic [5:0] wl,
  input  wire logic [8:0] flen,
  // Link
  input  wire logic       bclk,
  input  wire logic       sdin,
  output logic            bclk_c,
  output logic            wclk_c,
  output logic            ck_oe,
  output logic            sd_o,
  output logic            sd_oe
);
  logic [255:0] line;
  int           i;

  assign ck_oe = en && master;
  assign sd_oe = en && out_en;

  always @(posedge bclk or negedge en) begin
    if (!en) begin
      line <= '0;
    end else begin
      line <= {line[254:0], sdin};
    end
  end

  // A whole frame of delay returns every bit in its own slot, whatever the format or offset.
  always @(negedge bclk or negedge en) begin
    if (!en) begin
      sd_o <= 1'b0;
    end else begin
      sd_o <= line[flen - 9'h001];
    end
  end

  // The bit clock stands still whenever the codec is not the running master.
  initial begin
    bclk_c = 1'b0;
    wclk_c = 1'b0;
    #17;
    forever begin
      if (en && master) begin
        for (i = 0; i < 2 * wl; i++) begin
          #160 bclk_c = 1'b0;
          wclk_c = (i < wl);
          #160 bclk_c = 1'b1;
        end
      end else begin
        #40 bclk_c = 1'b0;
      end
    end
  end
endmodule : dai_codec_model

// file: verif/dai_host_bench.sv
// Bench for the audio serial port host against an echoing codec model.
`timescale 1ns/1ps
module dai_host_bench;
  logic               ref_clk, reset, tx_valid, tx_ready, rx_valid, mclk_o, synced;
  logic               bclk_o, bclk_oe, wclk_o, wclk_oe, serial_in_o;
  logic               c_bclk, c_wclk, c_ck_oe, c_sd, c_sd_oe, m_en, m_oe, m_mst, feed, mon;
  dai_pkg::dai_cfg_t  cfg;
  dai_pkg::dai_pair_t tx_data, rx_data;
  logic [8:0]         flen;
  logic [5:0]         wl;
  logic [63:0]        q[$];
  int                 fail_count, compares, rx_n, cyc;
  wire                bclk_w = bclk_oe ? bclk_o : c_ck_oe & c_bclk;
  wire                wclk_w = wclk_oe ? wclk_o : c_ck_oe & c_wclk;
  // The codec data line has a pull-down, so a floating codec reads as zero.
  wire                sdo_w = c_sd_oe & c_sd;

  dai_host DUT (.ref_clk(ref_clk), .reset(reset), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .mclk_o(mclk_o), .bclk_o(bclk_o),
    .bclk_oe(bclk_oe), .bclk_i(bclk_w), .wclk_o(wclk_o), .wclk_oe(wclk_oe), .wclk_i(wclk_w),
    .serial_in_o(serial_in_o), .serial_out_i(sdo_w), .synced(synced));

  dai_codec_model u_codec (.en(m_en), .out_en(m_oe), .master(m_mst), .wl(wl), .flen(flen), .bclk(bclk_w),
    .sdin(serial_in_o), .bclk_c(c_bclk), .wclk_c(c_wclk), .ck_oe(c_ck_oe), .sd_o(c_sd), .sd_oe(c_sd_oe));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic finish_test;
    $display("Counts: %0d compares, %0d fail_count", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [63:0] sx(input logic [63:0] d, input int w, input logic mono);
    logic [31:0] l;
    logic [31:0] r;
    l = d[63:32] << (32 - w);
    r = d[31:0] << (32 - w);
    l = $signed(l) >>> (32 - w);
    r = $signed(r) >>> (32 - w);
    return {l, mono ? 32'h0000_0000 : r};
  endfunction : sx

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fail_count++;
      finish_test();
    end
  end

  always @(posedge ref_clk) begin
    tx_valid <= feed;
    if (tx_valid && tx_ready) begin
      q.push_back(sx(tx_data, wl, cfg.slot_en && cfg.slot_mono));
      tx_data <= {$urandom, $urandom};
    end
  end

  always @(posedge ref_clk) begin
    if (mon && rx_valid) begin
      rx_n <= rx_n + 1;
      check(rx_data, (m_oe && q.size() > 0) ? q.pop_front() : 64'h0000_0000_0000_0000);
    end
  end

  // Feeding stops early so that the buffer drains and underrun frames are seen as zeros.
  task automatic run(input logic [1:0] fmt, ws, fs, input logic se, mo, oe, input logic [7:0] off);
    int n;
    wl = (ws == 2'h3) ? dai_pkg::WL_32 : dai_pkg::WL_16 + {2'h0, ws, 2'h0};
    flen = (fs == 2'h0) ? {2'h0, wl, 1'b0} : (fs == 2'h1) ? dai_pkg::FR_256 :
           (fs == 2'h2) ? dai_pkg::FR_128 : dai_pkg::FR_64;
    cfg <= '{1'b0, 1'b0, dai_pkg::dai_fmt_t'(fmt), ws, fs, se, mo, off};
    m_oe <= oe;
    q.delete();
    q.push_back(64'h0000_0000_0000_0000);
    feed <= 1'b1;
    rx_n <= 0;
    repeat (2) @(posedge ref_clk);
    for (n = 0; n < 40 && tx_ready !== 1'b0; n++)
      @(posedge ref_clk);
    cfg.port_en <= 1'b1;
    m_en <= 1'b1;
    mon <= 1'b1;
    for (n = 0; n < 40000 && rx_n < 3; n++)
      @(posedge ref_clk);
    feed <= 1'b0;
    for (n = 0; n < 40000 && rx_n < 13; n++)
      @(posedge ref_clk);
    mon <= 1'b0;
    cfg.port_en <= 1'b0;
    m_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    $display("Test done: format %0d word %0d frame %0d", fmt, wl, flen);
  endtask : run

  task automatic run_codec_master;
    int n;
    wl = dai_pkg::WL_16;
    flen = 9'h020;
    cfg <= '{1'b1, 1'b1, dai_pkg::FMT_LJ, 2'h0, 2'h0, 1'b0, 1'b0, 8'h00};
    m_mst <= 1'b1;
    m_en <= 1'b1;
    for (n = 0; n < 4000 && synced !== 1'b1; n++)
      @(posedge ref_clk);
    check(64'(synced), 64'h0000_0000_0000_0001);
    cfg.port_en <= 1'b0;
    m_en <= 1'b0;
    m_mst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    $display("Test done: codec as clock master");
  endtask : run_codec_master

  initial begin
    reset = 1'b1;
    cfg = '0;
    tx_valid = 1'b0;
    tx_data = '0;
    feed = 1'b0;
    mon = 1'b0;
    m_en = 1'b0;
    m_oe = 1'b1;
    m_mst = 1'b0;
    wl = 6'h10;
    flen = 9'h020;
    fail_count = 0;
    compares = 0;
    rx_n = 0;
    cyc = 0;
    void'($urandom(35));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    run(2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 8'h00);
    run(2'h0, 2'h1, 2'h3, 1'b0, 1'b0, 1'b1, 8'h00);
    run(2'h2, 2'h2, 2'h2, 1'b0, 1'b0, 1'b1, 8'h00);
    run(2'h3, 2'h3, 2'h0, 1'b0, 1'b0, 1'b1, 8'h00);
    run(2'h1, 2'h0, 2'h3, 1'b1, 1'b0, 1'b1, 8'h03);
    run(2'h3, 2'h0, 2'h3, 1'b1, 1'b0, 1'b1, 8'h05);
    run(2'h1, 2'h2, 2'h3, 1'b1, 1'b1, 1'b1, 8'h00);
    run(2'h0, 2'h3, 2'h1, 1'b0, 1'b0, 1'b1, 8'h00);
    run(2'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 8'h00);
    run_codec_master();
    finish_test();
  end
endmodule : dai_host_bench
